/* File: comc_pkg.sv */
// Constants and types for the operating-mode control block.
// Assumes a single core clock; no software-visible registers.
package comc_pkg;

  // ****************************************
  // Modes, Gray coded along real-prot-ext
  // ****************************************
  typedef enum logic [1:0] {
    COMC_REAL = 2'h0,
    COMC_PROT = 2'h1,
    COMC_EXT  = 2'h3,
    COMC_SMM  = 2'h2
  } comc_mode_e;

  // ****************************************
  // Size codes for address and operand
  // ****************************************
  localparam logic [1:0] COMC_SZ_16 = 2'h0;
  localparam logic [1:0] COMC_SZ_32 = 2'h1;
  localparam logic [1:0] COMC_SZ_64 = 2'h2;

  // ****************************************
  // Register file shape and reset values
  // ****************************************
  localparam logic [4:0] COMC_REGS_LEGACY = 5'h08;
  localparam logic [4:0] COMC_REGS_WIDE = 5'h10;
  localparam logic [6:0] COMC_GPR_W_LEGACY = 7'h20;
  localparam logic [6:0] COMC_GPR_W_WIDE = 7'h40;
  localparam int COMC_CTX_W = 32;
  localparam comc_mode_e COMC_RST_MODE = COMC_REAL;
  localparam logic COMC_RST_PIN_N = 1'h1;

endpackage

/* File: comc_ctx_store.sv */
// Context store for management-state entry and exit.
// Assumes save and restore never fall in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module comc_ctx_store (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic save,
  input wire logic restore,
  input wire logic [1:0] mode_in,
  input wire logic sub64_in,
  input wire logic v86_in,
  input wire logic cs32_in,
  input wire logic [comc_pkg::COMC_CTX_W-1:0] ctx_in,
  output logic [1:0] mode_out,
  output logic sub64_out,
  output logic v86_out,
  output logic cs32_out,
  output logic [comc_pkg::COMC_CTX_W-1:0] ctx_out,
  output logic restored
);

  // ****************************************
  // Saved image, held untouched while managed
  // ****************************************
  logic [comc_pkg::COMC_CTX_W+4:0] img_q;
  logic restored_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      img_q <= '0;
      restored_q <= 1'h0;
    end else begin
      if (save) begin
        img_q <= {mode_in, sub64_in, v86_in, cs32_in, ctx_in};
      end
      restored_q <= restore;
    end
  end

  assign mode_out = img_q[comc_pkg::COMC_CTX_W+4:comc_pkg::COMC_CTX_W+3];
  assign sub64_out = img_q[comc_pkg::COMC_CTX_W+2];
  assign v86_out = img_q[comc_pkg::COMC_CTX_W+1];
  assign cs32_out = img_q[comc_pkg::COMC_CTX_W];
  assign ctx_out = img_q[comc_pkg::COMC_CTX_W-1:0];
  assign restored = restored_q;

endmodule
`default_nettype wire

/* File: comc_top.sv */
// Operating-mode control: mode state, sub-modes and size defaults.
// Assumes instruction boundary and prefix inputs come from the decoder.
//
// Function
// - Reset and power-up leave the core in real-address mode.
// - Management pin falling edge or controller message enters management.
// - Entry saves running context and selects the separate address space.
// - Resume restores exactly the pre-interrupt mode, attributes and context.
// - Virtual-8086 is a per-task attribute within protected mode only.
// - Compatibility sub-mode chosen per code segment in extended mode.
// - Compatibility limits linear space to 4 GByte, sizes 16/32 only.
// - Compatibility refuses virtual-8086 tasks and hardware task switches.
// - Compatibility grants all privilege levels of protected and 64-bit.
// - Compatibility keeps physical address extension above 4 GByte.
// - 64-bit sub-mode gives 16 registers, general ones 64 bits wide.
// - 64-bit sub-mode chosen per code segment under system control.
// - 64-bit sub-mode defaults to 64-bit address, 32-bit operand.
// - Extension prefix with size override picks operand size; enables regs.
`timescale 1ns/100ps
`default_nettype none
module comc_top (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic INSN_BOUNDARY,
  input wire logic MGMT_INTERRUPT_PIN_N,
  input wire logic PIC_MGMT_MSG,
  input wire logic RESUME_REQ,
  input wire logic MODE_REQ_VALID,
  input wire logic [1:0] MODE_REQ,
  input wire logic TASK_V86,
  input wire logic TASK_SWITCH_REQ,
  input wire logic CS_LONG,
  input wire logic CS_DEFAULT32,
  input wire logic PFX_REGEXT_W,
  input wire logic PFX_OPSIZE,
  input wire logic [comc_pkg::COMC_CTX_W-1:0] CTX_IN,
  output logic [1:0] MODE,
  output logic SUB64,
  output logic V86_ACTIVE,
  output logic MGMT_SPACE_SEL,
  output logic CTX_SAVE,
  output logic CTX_RESTORE,
  output logic [comc_pkg::COMC_CTX_W-1:0] CTX_OUT,
  output logic [1:0] ADDR_SIZE,
  output logic [1:0] OPND_SIZE,
  output logic [4:0] GPR_COUNT,
  output logic [6:0] GPR_WIDTH,
  output logic REGEXT_EN,
  output logic LIN_LIMIT_4G,
  output logic PAE_ALLOWED,
  output logic ALL_PRIV_LEVELS,
  output logic TASK_MGMT_EN,
  output logic TASK_FAULT
);

  // ****************************************
  // Reset release through two flops
  // ****************************************
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_q <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_s1_q <= 1'h1;
      rst_n <= rst_s1_q;
    end
  end

  // ****************************************
  // Size decode, shared by all modes
  // ****************************************
  function automatic logic [3:0] comc_sizes(input logic [1:0] m,
      input logic s64, input logic d32, input logic w, input logic o);
    logic [1:0] dflt;
    dflt = d32 ? comc_pkg::COMC_SZ_32 : comc_pkg::COMC_SZ_16;
    if (m == comc_pkg::COMC_EXT && s64) begin
      // Width prefix beats the size override
      comc_sizes = {comc_pkg::COMC_SZ_64, w ? comc_pkg::COMC_SZ_64 :
                    (o ? comc_pkg::COMC_SZ_16 : comc_pkg::COMC_SZ_32)};
    end else if (m == comc_pkg::COMC_PROT || m == comc_pkg::COMC_EXT) begin
      comc_sizes = {dflt, o ? (d32 ? comc_pkg::COMC_SZ_16 :
                    comc_pkg::COMC_SZ_32) : dflt};
    end else begin
      comc_sizes = {comc_pkg::COMC_SZ_16, o ? comc_pkg::COMC_SZ_32 :
                    comc_pkg::COMC_SZ_16};
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  comc_pkg::comc_mode_e mode_q, mode_d;
  logic sub64_q, sub64_d, v86_q, v86_d, cs32_q, cs32_d;
  logic pin_prev_q, smi_pend_q, smi_pend_d, rsm_pend_q, rsm_pend_d;
  logic req_pend_q, req_pend_d;
  logic [1:0] req_mode_q;
  logic [1:0] sv_mode;
  logic sv_sub64, sv_v86, sv_cs32, restored;
  logic [comc_pkg::COMC_CTX_W-1:0] sv_ctx;
  logic [3:0] sizes_d;
  logic [comc_pkg::COMC_CTX_W-1:0] ctx_out_d;

  wire in_smm = (mode_q == comc_pkg::COMC_SMM);
  wire smi_ev = (pin_prev_q & ~MGMT_INTERRUPT_PIN_N) | PIC_MGMT_MSG;
  wire take_smi = INSN_BOUNDARY & smi_pend_q & ~in_smm;
  wire take_rsm = INSN_BOUNDARY & rsm_pend_q & in_smm;
  wire req_ok = (req_mode_q != comc_pkg::COMC_SMM);
  wire take_req = INSN_BOUNDARY & req_pend_q & ~in_smm & ~smi_pend_q;
  wire compat = (mode_q == comc_pkg::COMC_EXT) & ~sub64_q;
  wire fault_d = INSN_BOUNDARY & compat & (TASK_V86 | TASK_SWITCH_REQ);

  // Set wins over clear so an event in the taking cycle is kept
  assign smi_pend_d = smi_ev | (smi_pend_q & ~take_smi);
  assign rsm_pend_d = (RESUME_REQ & in_smm) | (rsm_pend_q & ~take_rsm);
  assign req_pend_d = MODE_REQ_VALID | (req_pend_q & ~take_req);

  always_comb begin
    mode_d = mode_q;
    sub64_d = sub64_q;
    v86_d = v86_q;
    cs32_d = cs32_q;
    if (take_smi) begin
      mode_d = comc_pkg::COMC_SMM;
      v86_d = 1'h0;
      sub64_d = 1'h0;
      cs32_d = 1'h0;
    end else if (take_rsm) begin
      mode_d = comc_pkg::comc_mode_e'(sv_mode);
      sub64_d = sv_sub64;
      v86_d = sv_v86;
      cs32_d = sv_cs32;
    end else if (INSN_BOUNDARY && !in_smm) begin
      if (take_req && req_ok) begin
        mode_d = comc_pkg::comc_mode_e'(req_mode_q);
      end
      // Code segment attributes pick the sub-mode per segment
      sub64_d = (mode_d == comc_pkg::COMC_EXT) & CS_LONG;
      cs32_d = CS_DEFAULT32;
      v86_d = (mode_d == comc_pkg::COMC_PROT) & TASK_V86;
    end
  end

  assign sizes_d = comc_sizes(mode_d, sub64_d, cs32_d, PFX_REGEXT_W,
                              PFX_OPSIZE);
  assign ctx_out_d = take_rsm ? sv_ctx : CTX_OUT;

  comc_ctx_store u_store (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .save(take_smi),
    .restore(take_rsm),
    .mode_in(mode_q),
    .sub64_in(sub64_q),
    .v86_in(v86_q),
    .cs32_in(cs32_q),
    .ctx_in(CTX_IN),
    .mode_out(sv_mode),
    .sub64_out(sv_sub64),
    .v86_out(sv_v86),
    .cs32_out(sv_cs32),
    .ctx_out(sv_ctx),
    .restored(restored)
  );

  // ****************************************
  // Core state flops
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= comc_pkg::COMC_RST_MODE;
      sub64_q <= 1'h0;
      v86_q <= 1'h0;
      cs32_q <= 1'h0;
      pin_prev_q <= comc_pkg::COMC_RST_PIN_N;
      smi_pend_q <= 1'h0;
      rsm_pend_q <= 1'h0;
      req_pend_q <= 1'h0;
      req_mode_q <= 2'h0;
    end else begin
      mode_q <= mode_d;
      sub64_q <= sub64_d;
      v86_q <= v86_d;
      cs32_q <= cs32_d;
      pin_prev_q <= MGMT_INTERRUPT_PIN_N;
      smi_pend_q <= smi_pend_d;
      rsm_pend_q <= rsm_pend_d;
      req_pend_q <= req_pend_d;
      if (MODE_REQ_VALID) begin
        req_mode_q <= MODE_REQ;
      end
    end
  end

  // ****************************************
  // Registered outputs, decoded from next state; task fault from current state
  // ****************************************
  wire is64_d = (mode_d == comc_pkg::COMC_EXT) & sub64_d;
  wire cmp_d = (mode_d == comc_pkg::COMC_EXT) & ~sub64_d;
  wire prot_d = (mode_d == comc_pkg::COMC_PROT);

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      MODE <= comc_pkg::COMC_RST_MODE;
      SUB64 <= 1'h0;
      V86_ACTIVE <= 1'h0;
      MGMT_SPACE_SEL <= 1'h0;
      CTX_SAVE <= 1'h0;
      CTX_RESTORE <= 1'h0;
      CTX_OUT <= '0;
      ADDR_SIZE <= comc_pkg::COMC_SZ_16;
      OPND_SIZE <= comc_pkg::COMC_SZ_16;
      GPR_COUNT <= comc_pkg::COMC_REGS_LEGACY;
      GPR_WIDTH <= comc_pkg::COMC_GPR_W_LEGACY;
      REGEXT_EN <= 1'h0;
      LIN_LIMIT_4G <= 1'h1;
      PAE_ALLOWED <= 1'h0;
      ALL_PRIV_LEVELS <= 1'h0;
      TASK_MGMT_EN <= 1'h0;
      TASK_FAULT <= 1'h0;
    end else begin
      MODE <= mode_d;
      SUB64 <= sub64_d;
      V86_ACTIVE <= v86_d;
      MGMT_SPACE_SEL <= (mode_d == comc_pkg::COMC_SMM);
      CTX_SAVE <= take_smi;
      CTX_RESTORE <= take_rsm;
      CTX_OUT <= ctx_out_d;
      ADDR_SIZE <= sizes_d[3:2];
      OPND_SIZE <= sizes_d[1:0];
      GPR_COUNT <= is64_d ? comc_pkg::COMC_REGS_WIDE :
                   comc_pkg::COMC_REGS_LEGACY;
      GPR_WIDTH <= is64_d ? comc_pkg::COMC_GPR_W_WIDE :
                   comc_pkg::COMC_GPR_W_LEGACY;
      REGEXT_EN <= is64_d;
      LIN_LIMIT_4G <= ~is64_d;
      PAE_ALLOWED <= prot_d | cmp_d;
      ALL_PRIV_LEVELS <= prot_d | (mode_d == comc_pkg::COMC_EXT);
      TASK_MGMT_EN <= prot_d;
      TASK_FAULT <= fault_d;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n);

  smi_entry_a: assert property (
    smi_pend_q && INSN_BOUNDARY && !in_smm |=> MODE == comc_pkg::COMC_SMM
    && MGMT_SPACE_SEL && CTX_SAVE)
    else $error("management entry missed");
  mode_hold_a: assert property (
    !INSN_BOUNDARY |=> $stable(MODE) && $stable(SUB64))
    else $error("mode changed off a boundary");
  resume_mode_a: assert property (
    take_rsm |=> MODE == sv_mode && SUB64 == sv_sub64
    && V86_ACTIVE == sv_v86 && CTX_RESTORE && CTX_OUT == sv_ctx && restored)
    else $error("resume did not restore state");
  compat_size_a: assert property (
    MODE == comc_pkg::COMC_EXT && !SUB64 |-> LIN_LIMIT_4G
    && ADDR_SIZE != comc_pkg::COMC_SZ_64 && OPND_SIZE != comc_pkg::COMC_SZ_64)
    else $error("compat sizes wrong");
  compat_v86_a: assert property (
    MODE == comc_pkg::COMC_EXT |-> !V86_ACTIVE && !TASK_MGMT_EN)
    else $error("v86 or task switch in extended mode");
  long_regs_a: assert property (
    MODE == comc_pkg::COMC_EXT && SUB64 |-> GPR_COUNT == 5'h10
    && GPR_WIDTH == 7'h40 && REGEXT_EN && ADDR_SIZE == comc_pkg::COMC_SZ_64)
    else $error("64-bit resources wrong");
  long_opnd_a: assert property (
    INSN_BOUNDARY && mode_d == comc_pkg::COMC_EXT && sub64_d
    && !PFX_REGEXT_W && !PFX_OPSIZE |=> OPND_SIZE == comc_pkg::COMC_SZ_32)
    else $error("64-bit default operand not 32");
  v86_prot_a: assert property (
    V86_ACTIVE |-> MODE == comc_pkg::COMC_PROT)
    else $error("v86 outside protected mode");
  priv_pae_a: assert property (
    MODE == comc_pkg::COMC_EXT && !SUB64 |-> ALL_PRIV_LEVELS && PAE_ALLOWED)
    else $error("compat privilege or extension lost");
  reset_real_a: assert property (
    $rose(rst_n) |-> MODE == comc_pkg::COMC_REAL)
    else $error("not real mode after reset");

  smi_seen_c: cover property (take_smi ##[1:20] take_rsm);
  long_seen_c: cover property (MODE == comc_pkg::COMC_EXT && SUB64);
  fault_seen_c: cover property (TASK_FAULT);
  v86_seen_c: cover property (V86_ACTIVE);

endmodule
`default_nettype wire

/* File: comc_mgmt_src.sv */
// Behavioural source of management interrupts for the mode block.
// Assumes the bench calls its tasks just after a clock edge.
`timescale 1ns/100ps
`default_nettype none
module comc_mgmt_src (
  input wire logic clk,
  output logic pin_n,
  output logic msg
);
  // ****************************************
  // Event tasks
  // ****************************************
  // Pin idles high, as a pulled-up active-low line would
  initial begin
    pin_n = 1'b1;
    msg = 1'b0;
  end

  // Held low three cycles so a slow sampler still sees the fall
  task automatic pin_event();
    @(posedge clk);
    #1 pin_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 pin_n = 1'b1;
  endtask

  task automatic msg_event();
    @(posedge clk);
    #1 msg = 1'b1;
    @(posedge clk);
    #1 msg = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the operating-mode control block.
// Assumes the management source model is compiled before this file.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_top;
  // ****************************************
  // Stimulus, model and checks
  // ****************************************
  logic clk = 1'b0, rstn = 1'b0, bd = 1'b0, rsm = 1'b0, rv = 1'b0;
  logic [1:0] rq = 2'h0;
  logic v86 = 1'b0, tsw = 1'b0, lng = 1'b0, d32 = 1'b0;
  logic w = 1'b0, osz = 1'b0, pin_n, msg;
  logic [31:0] ctx = 32'h0, cout;
  logic [1:0] mode, asz, osz_o;
  logic sub64, v86a, msel, csave, crest, rxe, lim, physical_address_extension, priv, tme, tf;
  logic [4:0] gcnt;
  logic [6:0] gw;
  int fail_count = 0, checked = 0;

  always #5 clk = ~clk;

  comc_mgmt_src comc_mgmt_src_inst (.clk(clk), .pin_n(pin_n), .msg(msg));

  comc_top comc_top_inst (
    .CORE_CLK(clk), .RSTN(rstn), .INSN_BOUNDARY(bd),
    .MGMT_INTERRUPT_PIN_N(pin_n), .PIC_MGMT_MSG(msg),
    .RESUME_REQ(rsm), .MODE_REQ_VALID(rv), .MODE_REQ(rq),
    .TASK_V86(v86), .TASK_SWITCH_REQ(tsw), .CS_LONG(lng),
    .CS_DEFAULT32(d32), .PFX_REGEXT_W(w), .PFX_OPSIZE(osz),
    .CTX_IN(ctx), .MODE(mode), .SUB64(sub64), .V86_ACTIVE(v86a),
    .MGMT_SPACE_SEL(msel), .CTX_SAVE(csave), .CTX_RESTORE(crest),
    .CTX_OUT(cout), .ADDR_SIZE(asz), .OPND_SIZE(osz_o),
    .GPR_COUNT(gcnt), .GPR_WIDTH(gw), .REGEXT_EN(rxe),
    .LIN_LIMIT_4G(lim), .PAE_ALLOWED(physical_address_extension), .ALL_PRIV_LEVELS(priv),
    .TASK_MGMT_EN(tme), .TASK_FAULT(tf));

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step();
    @(posedge clk);
    #1;
  endtask

  // Outputs of the boundary are settled when this returns
  task automatic bnd();
    bd = 1'b1;
    step();
    bd = 1'b0;
  endtask

  task automatic req(input logic [1:0] m);
    rv = 1'b1;
    rq = m;
    step();
    rv = 1'b0;
    step();
  endtask

  task automatic resume();
    rsm = 1'b1;
    step();
    rsm = 1'b0;
    step();
    bnd();
  endtask

  task automatic t_reset();
    rstn = 1'b0;
    repeat (6) step();
    rstn = 1'b1;
    repeat (3) step();
    `CHK(mode, comc_pkg::COMC_REAL);
    `CHK({sub64, msel, gcnt, gw, lim}, {2'h0, 5'h08, 7'h20, 1'h1});
    `CHK({asz, osz_o}, 4'h0);
    req(2'h2);
    bnd();
    `CHK(mode, comc_pkg::COMC_REAL);
    $display("Test reset done");
  endtask

  task automatic t_prot();
    req(2'h1);
    `CHK(mode, comc_pkg::COMC_REAL);
    v86 = 1'b1;
    d32 = 1'b1;
    osz = 1'b1;
    bnd();
    `CHK({mode, v86a, tme}, {comc_pkg::COMC_PROT, 2'h3});
    `CHK({asz, osz_o}, {comc_pkg::COMC_SZ_32, comc_pkg::COMC_SZ_16});
    `CHK({physical_address_extension, priv}, 2'h3);
    osz = 1'b0;
    $display("Test protected done");
  endtask

  task automatic t_mgmt_pin();
    ctx = 32'h5a5a_c3c3;
    comc_mgmt_src_inst.pin_event();
    bnd();
    `CHK({mode, msel, csave}, {comc_pkg::COMC_SMM, 2'h3});
    ctx = 32'h0;
    step();
    `CHK(csave, 1'h0);
    req(2'h0);
    bnd();
    `CHK(mode, comc_pkg::COMC_SMM);
    resume();
    `CHK({mode, v86a, crest}, {comc_pkg::COMC_PROT, 2'h3});
    `CHK(cout, 32'h5a5a_c3c3);
    step();
    `CHK(crest, 1'h0);
    bnd();
    `CHK({mode, v86a}, {comc_pkg::COMC_REAL, 1'h0});
    v86 = 1'b0;
    $display("Test management pin done");
  endtask

  // Rows: regext-w, opsize, expected operand size
  task automatic t_long();
    logic [3:0] tbl [4] = '{4'h1, 4'h4, 4'ha, 4'he};
    req(2'h3);
    lng = 1'b1;
    foreach (tbl[i]) begin
      {w, osz} = tbl[i][3:2];
      bnd();
      `CHK(osz_o, tbl[i][1:0]);
      // Let an edge pass so the boundary strobe is not raised again at once
      step();
    end
    `CHK({mode, sub64, asz}, {comc_pkg::COMC_EXT, 1'h1, 2'h2});
    `CHK({gcnt, gw, rxe, lim}, {5'h10, 7'h40, 2'h2});
    {w, osz} = 2'h0;
    $display("Test 64-bit done");
  endtask

  task automatic t_mgmt_msg();
    ctx = 32'h0f1e_2d3c;
    comc_mgmt_src_inst.msg_event();
    bnd();
    `CHK({mode, csave, asz}, {comc_pkg::COMC_SMM, 1'h1, 2'h0});
    resume();
    `CHK({mode, sub64, asz}, {comc_pkg::COMC_EXT, 1'h1, 2'h2});
    `CHK(cout, 32'h0f1e_2d3c);
    $display("Test management message done");
  endtask

  task automatic t_compat();
    lng = 1'b0;
    step();
    bnd();
    `CHK({mode, sub64, asz, osz_o}, {comc_pkg::COMC_EXT, 5'h05});
    `CHK({lim, physical_address_extension, priv, tme, gcnt}, {4'he, 5'h08});
    v86 = 1'b1;
    step();
    bnd();
    `CHK({tf, v86a}, 2'h2);
    step();
    `CHK(tf, 1'h0);
    v86 = 1'b0;
    tsw = 1'b1;
    bnd();
    `CHK({tf, tme}, 2'h2);
    tsw = 1'b0;
    $display("Test compatibility done");
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Whole sequence needs some 63 cycles; the limit is about thirty times that
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    t_reset();
    t_prot();
    t_mgmt_pin();
    t_long();
    t_mgmt_msg();
    t_compat();
    t_reset();
    stop_test();
  end
endmodule
`default_nettype wire
